// *** hdl/eis_skip_decoder.v ***
// decode and execute of the external interrupt 0 skip-test instructions
// How it works
// - enable 0: flag set skips and clears flag in the same cycle
// - enable bit 0 of reg a; 1 means nop
// - pin test opcode; one word, one cycle
// - select 0: skip when pin low
// - select 1: skip when pin high
// - select is bit 2 of reg b
`timescale 1ns/1ps
`include "eis_defs.vh"
module eis_skip_decoder (
  input wire ref_clk_i,
  input wire arst_n_i,
  input wire instr_valid_i,
  input wire [`EIS_OPC_W-1:0] instr_i,
  input wire [`EIS_REG_W-1:0] irq_control_reg_a_i,
  input wire [`EIS_REG_W-1:0] irq_control_reg_b_i,
  input wire ext_irq_request_flag_i,
  input wire ext_irq_pin_i,
  output reg skip_o,
  output reg suppress_o,
  output reg flag_clear_o,
  output reg hit_o
);
  reg skip_pend_ff;
  reg skip_ff;
  reg clr_ff;
  reg hit_ff;
  reg nxt_skip;
  reg nxt_clr;
  reg nxt_hit;
  wire pin_sync;
  wire ext_irq_enable_bit;
  wire pin_level_select_bit;
  wire live;

  eis_pin_sync u_sync (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .pin_i(ext_irq_pin_i),
    .pin_o(pin_sync)
  );

  assign ext_irq_enable_bit = irq_control_reg_a_i[`EIS_ENA_BIT];
  assign pin_level_select_bit = irq_control_reg_b_i[`EIS_SEL_BIT];
  // a word fetched into a skip slot is not live
  assign live = instr_valid_i & ~skip_pend_ff;

  ////////////////////////////////////////////////////////////////
  // decode in the executing cycle; carry is never touched
  always @* begin
    nxt_skip = 1'b0;
    nxt_clr = 1'b0;
    nxt_hit = 1'b0;
    if (live) begin
      case (instr_i)
        `EIS_OPC_FLAG_TEST: begin
          nxt_hit = 1'b1;
          if (!ext_irq_enable_bit && ext_irq_request_flag_i) begin
            nxt_skip = 1'b1;
            nxt_clr = 1'b1;
          end
        end
        `EIS_OPC_PIN_TEST: begin
          nxt_hit = 1'b1;
          // select sampled now, at execution
          nxt_skip = pin_level_select_bit ? pin_sync : ~pin_sync;
        end
        default: begin
          nxt_hit = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // skip pending holds until the next fetched word is absorbed
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      skip_pend_ff <= 1'b0;
      skip_ff <= 1'b0;
      clr_ff <= 1'b0;
      hit_ff <= 1'b0;
    end else begin
      if (instr_valid_i && skip_pend_ff) begin
        skip_pend_ff <= 1'b0;
      end else if (nxt_skip) begin
        skip_pend_ff <= 1'b1;
      end
      skip_ff <= nxt_skip;
      clr_ff <= nxt_clr;
      hit_ff <= nxt_hit;
    end
  end

  // outputs straight from flops
  always @* begin
    skip_o = skip_ff;
    suppress_o = skip_pend_ff;
    flag_clear_o = clr_ff;
    hit_o = hit_ff;
  end
endmodule

// *** inc/eis_defs.vh ***
// constants for the external interrupt skip-test decoder
`ifndef EIS_DEFS_VH
`define EIS_DEFS_VH
`define EIS_OPC_W 10
`define EIS_OPC_FLAG_TEST 10'h0bb
`define EIS_OPC_PIN_TEST 10'h03a
`define EIS_REG_W 4
`define EIS_ENA_BIT 0
`define EIS_SEL_BIT 2
`endif

// *** hdl/eis_pin_sync.v ***
// two-stage synchroniser for the external interrupt pin
`timescale 1ns/1ps
module eis_pin_sync (
  input wire ref_clk_i,
  input wire arst_n_i,
  input wire pin_i,
  output wire pin_o
);
  reg meta_ff;
  reg sync_ff;

  // first stage is read only by the second stage
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
    end else begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
    end
  end

  assign pin_o = sync_ff;
endmodule

// *** bench/eis_props.sv ***
// port checker for the skip-test decoder
`timescale 1ns/1ps
`include "eis_defs.vh"
module eis_props(input wire ref_clk_i,arst_n_i,instr_valid_i,input wire [9:0] instr_i,
input wire [3:0] irq_control_reg_a_i,irq_control_reg_b_i,
input wire ext_irq_request_flag_i,ext_irq_pin_i,skip_o,suppress_o,flag_clear_o,hit_o);
default clocking @(posedge ref_clk_i); endclocking
default disable iff (!arst_n_i);
// live decodes; a word under suppress never counts
wire f=instr_valid_i&&!suppress_o&&instr_i==`EIS_OPC_FLAG_TEST;
wire p=instr_valid_i&&!suppress_o&&instr_i==`EIS_OPC_PIN_TEST;
wire en=irq_control_reg_a_i[`EIS_ENA_BIT];
wire sel=irq_control_reg_b_i[`EIS_SEL_BIT];
sequence took_skip; skip_o&&hit_o&&suppress_o; endsequence
flag_skip_a: assert property(f&&!en&&ext_irq_request_flag_i|=>
took_skip ##0 flag_clear_o) else $error("flag skip");
flag_idle_a: assert property(f&&!en&&!ext_irq_request_flag_i|=>
!skip_o&&!flag_clear_o&&hit_o) else $error("flag idle");
flag_nop_a: assert property(f&&en|=>!skip_o&&!flag_clear_o&&hit_o)
else $error("flag nop");
pin_hit_a: assert property(p|=>hit_o&&!flag_clear_o) else $error("pin hit");
pin_skip_a: assert property(p&&sel==$past(ext_irq_pin_i,2)|=>took_skip)
else $error("pin skip");
pin_run_a: assert property(p&&sel!=$past(ext_irq_pin_i,2)|=>!skip_o)
else $error("pin run");
skipped_nop_a: assert property(suppress_o&&instr_valid_i|=>
!skip_o&&!hit_o&&!flag_clear_o&&!suppress_o) else $error("skipped nop");
endmodule
bind eis_skip_decoder eis_props u_props(.*);

// *** bench/eis_skip_decoder_bench.sv ***
// random bench with a cycle model of the skip decoder
`timescale 1ns/1ps
module eis_skip_decoder_bench;
reg clk=0,rst_n=0,v=0,fl=0,pn=1,t,u,ek,ec,eh,es=0,p1=1,p2=1;
reg [9:0] ins=0;reg [3:0] a=0,b=0;reg [31:0] r;wire sk,su,fc,ht;
integer errors=0,compares=0,seed=32'hd6758c8c,i;
eis_skip_decoder dut(.ref_clk_i(clk),.arst_n_i(rst_n),.instr_valid_i(v),.instr_i(ins),
.irq_control_reg_a_i(a),.irq_control_reg_b_i(b),.ext_irq_request_flag_i(fl),
.ext_irq_pin_i(pn),.skip_o(sk),.suppress_o(su),.flag_clear_o(fc),.hit_o(ht));
initial forever #2.5 clk=~clk;
task chk(input [3:0] s,x);begin
compares=compares+1;
if(s!==x)begin errors=errors+1;$display("Error %0t %h %h",$time,s,x);end
end endtask
task conclude;begin
$display("errors %0d compares %0d",errors,compares);
if(errors==0&&compares>0)$display("Testbench passed");
else $display("Testbench failed");
$finish;
end endtask
// model works on the inputs seen at each edge, pin through two sync stages
initial begin
repeat(4)@(posedge clk);
rst_n<=1;
for(i=0;i<3000;i=i+1)begin
@(posedge clk);
t=v&&!es&&ins==10'h0bb;u=v&&!es&&ins==10'h03a;
ec=t&&!a[0]&&fl;ek=ec||u&&b[2]==p2;eh=t||u;es=ek||es&&!v;p2=p1;p1=pn;
r=$random(seed);
{v,a,b,fl,pn}<=r[31:21];
ins<=r[1]?(r[0]?10'h0bb:10'h03a):r[11:2];
#1 chk({sk,su,fc,ht},{ek,es,ec,eh});
end
$display("random test done");
conclude;
end
endmodule
